// ===== rtl/bhc_pkg.sv
// Package for the bank scramble configuration block: offsets, fields, resets.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package bhc_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CONTROL      = 12'h550;
  localparam logic [11:0] OFS_FOLD_FIRST   = 12'h554;
  localparam logic [11:0] OFS_FOLD_SECOND  = 12'h558;
  localparam logic [11:0] OFS_FOLD_THIRD   = 12'h55c;

  // Control field positions
  localparam int unsigned CTL_ENABLE_BIT   = 0;
  localparam int unsigned CTL_TRIM_LSB     = 1;
  localparam int unsigned CTL_OFFSET_LSB   = 4;

  // Lowest bank bit sits at this base plus the offset field
  localparam logic [4:0]  BANK_BASE        = 5'h0a;
  // Trim value that selects eight banks
  localparam logic [2:0]  TRIM_EIGHT       = 3'h7;

  // Reset values
  localparam logic [31:0] RST_CONTROL      = 32'h0000_0000;
  localparam logic [31:0] RST_FOLD         = 32'h0000_0000;
  // Answer to an unmapped read
  localparam logic [31:0] RD_UNMAPPED      = 32'h0000_0000;

  // Control register contents
  typedef struct packed {
    logic [2:0] bank_offset;  // First bank bit above base
    logic [2:0] width_trim;   // Bank count trim
    logic       scramble_en;  // Hashing on
  } bhc_ctrl_t;

  // All configuration seen by the hashing path
  typedef struct packed {
    bhc_ctrl_t   ctrl;
    logic [31:0] fold_select_first;
    logic [31:0] fold_select_second;
    logic [31:0] fold_select_third;
  } bhc_cfg_t;

endpackage : bhc_pkg

// ===== rtl/bhc_top.sv
// Bank scramble configuration registers and address hashing for the scheduler.
// Assumes a classic Wishbone master on clk_i and a scheduler address on the same clock.
// How it works
// (R1) Lowest bank bit is ten plus offset
// (R2) Software writes trim zero for four banks
// (R3) Software writes trim ones for eight banks
// (R4) Hashing acts only while enable is set
// (R5) First mask folds bits into bank bit one
// (R6) Second mask folds bits into bank bit two
// (R7) Eight banks: software clears mask bits below R3
// (R8) Four banks: software clears mask bits below R0
// (R9) Third mask folds bits into bank bit three
// (R10) Bank bit xors with parity of masked address
// (R11) All configuration registers reset to zero
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none

module bhc_top (
  input  wire logic        clk_i,        // 25 MHz clock
  input  wire logic        rst_i,        // Synchronous reset, active high
  input  wire logic        cyc_i,        // Wishbone cycle
  input  wire logic        stb_i,        // Wishbone strobe
  input  wire logic        we_i,         // Wishbone write
  input  wire logic [11:0] adr_i,        // Wishbone byte address
  input  wire logic [3:0]  sel_i,        // Wishbone byte enables
  input  wire logic [31:0] dat_i,        // Wishbone write data
  output logic      [31:0] dat_o,        // Wishbone read data
  output logic             ack_o,        // Wishbone acknowledge
  input  wire logic [31:0] sched_addr_i, // Address from the scheduler
  output logic      [31:0] hashed_addr_o // Address with scrambled bank bits
);

  bhc_pkg::bhc_cfg_t cfg_reg;        // Configuration registers
  logic              ack_reg;        // Registered acknowledge
  logic [31:0]       rdata_reg;      // Registered read data
  logic [31:0]       hashed_reg;     // Registered hashed address
  logic [31:0]       hashed_next;    // Next hashed address
  logic [31:0]       ctrl_word;      // Control as a bus word
  logic              req;            // New bus request
  logic              wr_take;        // Write takes effect this edge
  logic [4:0]        bank_pos;       // Lowest bank bit position
  logic              eight_banks;    // Third bank bit in use
  logic [31:0]       ctrl_merged;    // Control word after byte-lane merge

  // Parity of the address bits picked by a mask
  function automatic logic fold_parity(input logic [31:0] addr, input logic [31:0] mask);
    fold_parity = ^(addr & mask);
  endfunction : fold_parity

  // Byte-lane merge of write data into a register
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    lane_merge = res;
  endfunction : lane_merge

  assign req         = cyc_i && stb_i && !ack_reg;
  assign wr_take     = cyc_i && stb_i && we_i && ack_reg;
  assign ctrl_word   = {25'h0, cfg_reg.ctrl};
  assign ctrl_merged = lane_merge(ctrl_word, dat_i, sel_i);
  assign bank_pos    = bhc_pkg::BANK_BASE + {2'h0, cfg_reg.ctrl.bank_offset}; // R1
  assign eight_banks = (cfg_reg.ctrl.width_trim == bhc_pkg::TRIM_EIGHT);    // R2 R3
  assign ack_o         = ack_reg;
  assign dat_o         = rdata_reg;
  assign hashed_addr_o = hashed_reg;

  // Acknowledge one cycle after a request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= req;
    end
  end

  // Read data captured at the request, held through the acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (req)
    begin
      unique case (adr_i)
        bhc_pkg::OFS_CONTROL:     rdata_reg <= ctrl_word;
        bhc_pkg::OFS_FOLD_FIRST:  rdata_reg <= cfg_reg.fold_select_first;
        bhc_pkg::OFS_FOLD_SECOND: rdata_reg <= cfg_reg.fold_select_second;
        bhc_pkg::OFS_FOLD_THIRD:  rdata_reg <= cfg_reg.fold_select_third;
        default:                  rdata_reg <= bhc_pkg::RD_UNMAPPED; // Unmapped reads zero
      endcase
    end
  end

  // Register writes take effect on the acknowledging edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_reg.ctrl               <= bhc_pkg::RST_CONTROL[6:0]; // R11
      cfg_reg.fold_select_first  <= bhc_pkg::RST_FOLD;         // R11
      cfg_reg.fold_select_second <= bhc_pkg::RST_FOLD;         // R11
      cfg_reg.fold_select_third  <= bhc_pkg::RST_FOLD;         // R11
    end
    else if (wr_take)
    begin
      unique case (adr_i)
        bhc_pkg::OFS_CONTROL:     cfg_reg.ctrl <= ctrl_merged[6:0]; // Reserved bits dropped
        bhc_pkg::OFS_FOLD_FIRST:  cfg_reg.fold_select_first  <= lane_merge(cfg_reg.fold_select_first, dat_i, sel_i);
        bhc_pkg::OFS_FOLD_SECOND: cfg_reg.fold_select_second <= lane_merge(cfg_reg.fold_select_second, dat_i, sel_i);
        bhc_pkg::OFS_FOLD_THIRD:  cfg_reg.fold_select_third  <= lane_merge(cfg_reg.fold_select_third, dat_i, sel_i);
        default:                  ;  // Unmapped writes ignored
      endcase
    end
  end

  // Bank bits flipped by their folded parity while enabled
  always_comb
  begin
    hashed_next = sched_addr_i;
    if (cfg_reg.ctrl.scramble_en) // R4 R10
    begin
      hashed_next[bank_pos] = sched_addr_i[bank_pos]
                              ^ fold_parity(sched_addr_i, cfg_reg.fold_select_first);  // R5
      hashed_next[bank_pos + 5'h01] = sched_addr_i[bank_pos + 5'h01]
                              ^ fold_parity(sched_addr_i, cfg_reg.fold_select_second); // R6
      if (eight_banks)
      begin
        hashed_next[bank_pos + 5'h02] = sched_addr_i[bank_pos + 5'h02]
                              ^ fold_parity(sched_addr_i, cfg_reg.fold_select_third);  // R9
      end
    end
  end

  // Hashed address registered for the scheduler
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hashed_reg <= 32'h0000_0000;
    end
    else
    begin
      hashed_reg <= hashed_next;
    end
  end

  // Helper: difference between output and the address it came from
  logic [31:0] sched_prev_reg; // Scheduler address at the previous edge
  logic [31:0] diff_w;         // Bits the hash flipped

  // Previous scheduler address, kept in clocked code for the checks
  always_ff @(posedge clk_i)
  begin
    sched_prev_reg <= sched_addr_i;
  end

  assign diff_w = hashed_reg ^ sched_prev_reg;

  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // Bus handshake, decided locally
    ack_o |=> !ack_o) else $error("ack held longer than one cycle");

  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i) // Bus handshake, decided locally
    (cyc_i && stb_i && !ack_o) |=> ack_o) else $error("request not answered next cycle");

  a_reset_config_zero: assert property (@(posedge clk_i) // R11
    $past(rst_i) |-> (cfg_reg == '0 && hashed_addr_o == 32'h0000_0000)) else $error("config not zero after reset");

  a_pass_when_off: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    ($past(!cfg_reg.ctrl.scramble_en) && !$past(rst_i)) |-> hashed_addr_o == $past(sched_addr_i))
    else $error("address altered while hashing off");

  a_bank_window: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    !$past(rst_i) |-> (diff_w & ~(32'h0000_0007 << $past(bank_pos))) == 32'h0000_0000)
    else $error("bit changed outside bank field");

  a_fold_first: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    ($past(cfg_reg.ctrl.scramble_en) && !$past(rst_i)) |->
      diff_w[$past(bank_pos)] == fold_parity($past(sched_addr_i), $past(cfg_reg.fold_select_first)))
    else $error("first bank bit hash wrong");

  a_fold_second: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    ($past(cfg_reg.ctrl.scramble_en) && !$past(rst_i)) |->
      diff_w[$past(bank_pos) + 5'h01] == fold_parity($past(sched_addr_i), $past(cfg_reg.fold_select_second)))
    else $error("second bank bit hash wrong");

  a_fold_third: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    ($past(cfg_reg.ctrl.scramble_en) && !$past(rst_i)) |->
      diff_w[$past(bank_pos) + 5'h02] == ($past(eight_banks)
        && fold_parity($past(sched_addr_i), $past(cfg_reg.fold_select_third))))
    else $error("third bank bit hash wrong");

  a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (wr_take && adr_i == bhc_pkg::OFS_FOLD_FIRST && sel_i == 4'hf) |=>
      cfg_reg.fold_select_first == $past(dat_i)) else $error("first mask write lost");

  a_mask_second_write: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (wr_take && adr_i == bhc_pkg::OFS_FOLD_SECOND && sel_i == 4'hf) |=>
      cfg_reg.fold_select_second == $past(dat_i)) else $error("second mask write lost");

  a_mask_third_write: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (wr_take && adr_i == bhc_pkg::OFS_FOLD_THIRD && sel_i == 4'hf) |=>
      cfg_reg.fold_select_third == $past(dat_i)) else $error("third mask write lost");

  a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i) // R1 R4
    (wr_take && adr_i == bhc_pkg::OFS_CONTROL && sel_i[0]) |=>
      cfg_reg.ctrl == $past(dat_i[6:0])) else $error("control write lost");

  a_lane_keep: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (wr_take && adr_i == bhc_pkg::OFS_FOLD_FIRST && !sel_i[0]) |=>
      cfg_reg.fold_select_first[7:0] == $past(cfg_reg.fold_select_first[7:0]))
    else $error("unselected mask byte changed");

endmodule : bhc_top

`default_nettype wire

// ===== verif/bhc_sched_model.sv
// Scheduler stand-in: issues one address a cycle toward the hashing path.
// Assumes the bench picks the address; it launches on the rising edge.
`timescale 1ns/1ps
`default_nettype none

module bhc_sched_model (
  input  wire logic        clk_i,  // Shared clock
  input  wire logic [31:0] pick_i, // Address to issue next
  output logic      [31:0] addr_o  // Address toward the block
);
  // Registered like the real scheduler output
  always_ff @(posedge clk_i)
  begin
    addr_o <= pick_i;
  end
endmodule : bhc_sched_model

`default_nettype wire

// ===== verif/bhc_top_tb.sv
// Bench for the bank scramble block: Wishbone register tests and hash checks.
// Assumes one 25 MHz clock and a scheduler model feeding the address input.
`timescale 1ns/1ps
`default_nettype none

module bhc_top_tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i; // Clock, reset, bus controls
  logic [11:0] adr_i;                            // Bus address
  logic [3:0]  sel_i;                            // Byte enables
  logic [31:0] dat_i, pick, rd;                  // Write data, next address, read data
  wire  [31:0] dat_o, hashed_addr_o, sched_addr; // Design and model outputs
  wire         ack_o;                            // Bus acknowledge
  int          failures, tests_run;              // Report counters
  logic [31:0] m [3];                            // Masks as written
  logic [11:0] ofs [5] = '{bhc_pkg::OFS_CONTROL, bhc_pkg::OFS_FOLD_FIRST,
    bhc_pkg::OFS_FOLD_SECOND, bhc_pkg::OFS_FOLD_THIRD, 12'h560};
  logic [31:0] ctl [5] = '{32'h0, 32'h1, 32'hf, 32'h71, 32'h7f}; // Control cases

  bhc_top u_bhc_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sched_addr_i(sched_addr), .hashed_addr_o(hashed_addr_o));
  bhc_sched_model u_bhc_sched_model (.clk_i(clk_i), .pick_i(pick), .addr_o(sched_addr));

  // Free-running 40 ns clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Counts, verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // Compare one 32-bit result
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // One classic Wishbone cycle, waiting for ack under a bound
  task wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= s; dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      close_out();
    end
  endtask : wb

  // Expected hash from the control word and masks
  function automatic logic [31:0] hash(input logic [31:0] a, input logic [31:0] c);
    int p;
    logic [31:0] r;
    p = 10 + c[6:4];
    r = a;
    if (c[0])
    begin
      r[p] ^= ^(a & m[0]);
      r[p+1] ^= ^(a & m[1]);
      if (c[3:1] == 3'h7) r[p+2] ^= ^(a & m[2]);
    end
    return r;
  endfunction : hash

  // Issue an address through the model and compare three edges later
  task hchk(input logic [31:0] a, input logic [31:0] c);
    @(posedge clk_i);
    pick <= a;
    repeat (3) @(posedge clk_i);
    cmp("hashed address", hash(a, c), hashed_addr_o);
  endtask : hchk

  // Main sequence
  initial
  begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 12'h000;
    sel_i = 4'h0; dat_i = 32'h0; pick = 32'h0; failures = 0; tests_run = 0;
    m = '{32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b0, ofs[i], 4'hf, 32'h0);
      cmp("reset read", 32'h0, rd);
    end
    hchk(32'hfedcba98, 32'h0);
    wb(1'b1, bhc_pkg::OFS_CONTROL, 4'hf, 32'hffffffff);
    wb(1'b0, bhc_pkg::OFS_CONTROL, 4'hf, 32'h0);
    cmp("control readback", 32'h7f, rd);
    // Masks only above the row boundary for either bank count
    m = '{32'h55800000, 32'h0f800000, 32'hf0800000};
    wb(1'b1, bhc_pkg::OFS_FOLD_FIRST, 4'hf, 32'haa800000);
    wb(1'b1, bhc_pkg::OFS_FOLD_FIRST, 4'h8, 32'h55000000);
    wb(1'b1, bhc_pkg::OFS_FOLD_SECOND, 4'hf, m[1]);
    wb(1'b1, bhc_pkg::OFS_FOLD_THIRD, 4'hf, m[2]);
    wb(1'b1, 12'h560, 4'hf, 32'hffffffff);
    for (int i = 1; i < 5; i++)
    begin
      wb(1'b0, ofs[i], 4'hf, 32'h0);
      cmp("mask readback", (i == 4) ? 32'h0 : m[i-1], rd);
    end
    // Trim written only as all zeros or all ones
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b1, bhc_pkg::OFS_CONTROL, 4'hf, ctl[i]);
      hchk(32'h12345678, ctl[i]);
      hchk(32'hfedcba98, ctl[i]);
    end
    // Reset in mid-run clears everything written above
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b0, ofs[i], 4'hf, 32'h0);
      cmp("read after reset", 32'h0, rd);
    end
    hchk(32'h12345678, 32'h0);
    close_out();
  end

  // Watchdog far beyond the expected run of some 130 cycles
  initial
  begin
    #200000;
    failures++;
    close_out();
  end
endmodule : bhc_top_tb

`default_nettype wire
